// *** design/fsbc_consts.vh ***
//
// Contract
// - control bit 3 picks transfer direction: clear means formatter to buffer, set means buffer to formatter.
// - while control bit 4 is set the byte counter carry is blocked from fetching the next control store word.
// - the carry inhibit bit clears itself on a counter carry once the sector size count is already zero.
// - sequencer branch commands can set and clear the carry inhibit bit besides software writes.
// - control bit 5 picks edge polarity: clear means rising edges only, set means falling edges only.
// - the chosen polarity feeds both the branch condition logic and the sector detected flag.
// - a read of the next address register returns in bits 0-4 the address the sequencer runs next.
// - the next address comes from start address, branch address, next address field or data branch field.
// - a write to the next address offset stores a 5-bit branch target used when a branch condition is met.
// - next address and branch address clear on chip reset or a sector formatter reset.
// - control bit 1 makes single-source branches take targets from the data branch field.
`ifndef FSBC_CONSTS_VH
`define FSBC_CONSTS_VH
`define FSBC_OFF_NEXT 12'h078
`define FSBC_OFF_CTRL 12'h077
`define FSBC_OFF_IRQ_STAT 12'h080
`define FSBC_OFF_IRQ_MASK 12'h084
`define FSBC_OFF_RESET 12'h04F
`define FSBC_CTRL_BRSRC 1
`define FSBC_CTRL_DIR 3
`define FSBC_CTRL_INH 4
`define FSBC_CTRL_POL 5
`define FSBC_CTRL_MASK 8'h3A
`define FSBC_ADDR_MASK 8'h1F
`define FSBC_IRQ_EDGE 0
`define FSBC_IRQ_AUTOCLR 1
`define FSBC_IRQ_BRANCH 2
`define FSBC_IRQ_MASK 8'h07
`endif

// *** design/fsbc_edge_detect.v ***
`timescale 1ns/10ps
// polarity selectable edge detector on the sector mark input
module fsbc_edge_detect (
   // clock and reset
   input wire pclk,
   input wire presetn,
   input wire sf_reset,
   // sense
   input wire falling_sel,
   input wire mark_in,
   // result
   output wire edge_hit
);
   reg last;
   // previous sample; input is taken as synchronous
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
      end else if (sf_reset) begin
         last <= mark_in;
      end else begin
         last <= mark_in;
      end
   end
   assign edge_hit = falling_sel ? (last & ~mark_in) : (~last & mark_in);
endmodule // fsbc_edge_detect

// *** design/fsbc_next_addr.v ***
`timescale 1ns/10ps
// next control store address selector and holder
module fsbc_next_addr (
   // clock and reset
   input wire pclk,
   input wire presetn,
   input wire sf_reset,
   // sources
   input wire start_load,
   input wire [4:0] start_addr,
   input wire [4:0] branch_addr,
   input wire [4:0] next_field,
   input wire [4:0] data_field,
   // control
   input wire advance,
   input wire branch_taken,
   input wire dual_source,
   input wire dual_pick_data,
   input wire use_data_field,
   // result
   output reg [4:0] next_addr
);
   reg [4:0] next_next_addr;
   // source pick, start wins, then branch, then sequential
   always @* begin
      next_next_addr = next_addr;
      if (start_load) begin
         next_next_addr = start_addr;
      end else if (advance && branch_taken) begin
         if (dual_source) begin
            next_next_addr = dual_pick_data ? data_field : branch_addr;
         end else begin
            next_next_addr = use_data_field ? data_field : branch_addr;
         end
      end else if (advance) begin
         next_next_addr = next_field;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_addr <= 5'h00;
      end else if (sf_reset) begin
         next_addr <= 5'h00;
      end else begin
         next_addr <= next_next_addr;
      end
   end
endmodule // fsbc_next_addr

// *** design/fsbc_top.v ***
`timescale 1ns/10ps
`include "fsbc_consts.vh"
// sequencer branch control with apb register access
module fsbc_top (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // sequencer side
   input wire byte_carry,
   input wire sector_count_zero,
   input wire start_load,
   input wire [4:0] start_addr,
   input wire [4:0] next_field,
   input wire [4:0] data_field,
   input wire branch_cond,
   input wire branch_is_edge,
   input wire dual_source,
   input wire dual_pick_data,
   input wire inh_set_cmd,
   input wire inh_clr_cmd,
   input wire sector_mark_edge_input,
   // outputs to formatter
   output wire fetch_next,
   output wire buffer_to_formatter,
   output wire sector_detected_set,
   output wire [4:0] next_addr,
   output wire irq
);
   ////////////////////////////////////////////////////////////////////////////
   reg [7:0] ctrl;
   reg [4:0] branch_addr;
   reg [7:0] irq_stat;
   reg [7:0] irq_mask;
   wire wr;
   wire rd;
   wire sf_reset;
   wire edge_hit;
   wire branch_taken;
   wire auto_clr;
   wire [7:0] irq_events;

   function sel;
      input [11:0] a;
      input [11:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   // zero wait state slave, write commits in access phase
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign sf_reset = wr & sel(paddr, `FSBC_OFF_RESET) & pwdata[0];

   ////////////////////////////////////////////////////////////////////////////
   // carry blocked while inhibit set
   assign fetch_next = byte_carry & ~ctrl[`FSBC_CTRL_INH];
   assign auto_clr = byte_carry & sector_count_zero & ctrl[`FSBC_CTRL_INH];
   assign buffer_to_formatter = ctrl[`FSBC_CTRL_DIR];
   assign sector_detected_set = edge_hit;
   assign branch_taken = branch_is_edge ? edge_hit : branch_cond;

   // control register; hardware inhibit updates beat software writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 8'h00;
      end else if (sf_reset) begin
         ctrl <= 8'h00;
      end else begin
         if (wr && sel(paddr, `FSBC_OFF_CTRL)) begin
            ctrl <= pwdata[7:0] & `FSBC_CTRL_MASK;
         end
         if (inh_set_cmd) begin
            ctrl[`FSBC_CTRL_INH] <= 1'b1;
         end else if (inh_clr_cmd || auto_clr) begin
            ctrl[`FSBC_CTRL_INH] <= 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         branch_addr <= 5'h00;
      end else if (sf_reset) begin
         branch_addr <= 5'h00;
      end else if (wr && sel(paddr, `FSBC_OFF_NEXT)) begin
         branch_addr <= pwdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign irq_events = {5'h00, branch_taken & fetch_next, auto_clr, edge_hit};
   // sticky status, set beats write-one clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 8'h00;
         irq_mask <= 8'h00;
      end else begin
         if (wr && sel(paddr, `FSBC_OFF_IRQ_MASK)) begin
            irq_mask <= pwdata[7:0] & `FSBC_IRQ_MASK;
         end
         if (wr && sel(paddr, `FSBC_OFF_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~pwdata[7:0]) | irq_events;
         end else begin
            irq_stat <= irq_stat | irq_events;
         end
      end
   end
   assign irq = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // read mux, registered data output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (sel(paddr, `FSBC_OFF_NEXT)) begin
            prdata <= {27'h0000000, next_addr};
         end else if (sel(paddr, `FSBC_OFF_CTRL)) begin
            prdata <= {24'h000000, ctrl};
         end else if (sel(paddr, `FSBC_OFF_IRQ_STAT)) begin
            prdata <= {24'h000000, irq_stat};
         end else if (sel(paddr, `FSBC_OFF_IRQ_MASK)) begin
            prdata <= {24'h000000, irq_mask};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   fsbc_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .sf_reset(sf_reset),
      .falling_sel(ctrl[`FSBC_CTRL_POL]),
      .mark_in(sector_mark_edge_input),
      .edge_hit(edge_hit)
   );

   // sequencer advances on an uninhibited carry
   fsbc_next_addr u_next (
      .pclk(pclk),
      .presetn(presetn),
      .sf_reset(sf_reset),
      .start_load(start_load),
      .start_addr(start_addr),
      .branch_addr(branch_addr),
      .next_field(next_field),
      .data_field(data_field),
      .advance(fetch_next),
      .branch_taken(branch_taken),
      .dual_source(dual_source),
      .dual_pick_data(dual_pick_data),
      .use_data_field(ctrl[`FSBC_CTRL_BRSRC]),
      .next_addr(next_addr)
   );
endmodule // fsbc_top

// *** tb/fsbc_monitor.sv ***
`timescale 1ns/10ps
// port checks on the branch control top
module fsbc_monitor (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // sequencer
   input wire byte_carry,
   input wire branch_cond,
   input wire branch_is_edge,
   input wire [4:0] next_field,
   input wire sector_mark_edge_input,
   input wire fetch_next,
   input wire buffer_to_formatter,
   input wire sector_detected_set,
   input wire [4:0] next_addr
);
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write commit and read setup strobes
   wire wr_go = psel && penable && pwrite;
   wire rd_go = psel && !penable && !pwrite;
   a_dir_follow: assert property (wr_go && paddr == 12'h077 |=>
      buffer_to_formatter == $past(pwdata[3])) else $error("direction bit wrong");
   a_ctrl_read: assert property (rd_go && paddr == 12'h077 |=>
      prdata[3] == $past(buffer_to_formatter)) else $error("control readback wrong");
   a_fetch_cause: assert property (fetch_next |-> byte_carry) else $error("stray fetch");
   a_edge_cause: assert property (sector_detected_set |->
      sector_mark_edge_input != $past(sector_mark_edge_input)) else $error("stray edge");
   a_field_step: assert property (fetch_next && !branch_cond && !branch_is_edge |=>
      next_addr == $past(next_field)) else $error("next field not taken");
   a_next_read: assert property (rd_go && paddr == 12'h078 |=>
      prdata == {27'h0, $past(next_addr)}) else $error("next address readback wrong");
   a_sf_clear: assert property (wr_go && paddr == 12'h04F && pwdata[0] |=>
      next_addr == 5'h00 && !buffer_to_formatter) else $error("formatter reset missed");
   a_rsvd_zero: assert property (psel && penable && !pwrite |->
      prdata[31:8] == 24'h0) else $error("reserved read bits set");
   c_fetch: cover property (fetch_next);
   c_edge: cover property (sector_detected_set);
   c_branch: cover property (fetch_next && branch_cond);
endmodule // fsbc_monitor

// *** tb/test_format_sequencer_branch_control.sv ***
`timescale 1ns/10ps
// self-checking bench; reads matched from a queue of expectations
module test_format_sequencer_branch_control;
   logic pclk, presetn, psel, penable, pwrite, byte_carry, sector_count_zero, start_load;
   logic branch_cond, branch_is_edge, dual_source, dual_pick_data, inh_set_cmd, inh_clr_cmd;
   logic sector_mark_edge_input;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [4:0] start_addr, next_field, data_field, b;
   logic [7:0] r;
   logic [31:0] exp_q[$];
   wire [31:0] prdata;
   wire pready, pslverr, fetch_next, buffer_to_formatter, sector_detected_set, irq;
   wire [4:0] next_addr;
   int err_total, comparisons, i;
   fsbc_top DUT (.*);
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      comparisons++;
      if (a !== e) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, a, e);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // request held until pready is seen high
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      // let the committing edge settle before callers look at outputs
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(0, a, 0);
   endtask
   // read data taken at the access edge
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready) chk(prdata, exp_q.pop_front());
   end
   // comb strobes checked once the edge settles
   task automatic carry(input logic z, input logic e);
      @(posedge pclk);
      byte_carry <= 1;
      sector_count_zero <= z;
      #1 chk(fetch_next, e);
      @(posedge pclk);
      byte_carry <= 0;
   endtask
   task automatic mk(input logic v, input logic e);
      @(posedge pclk);
      sector_mark_edge_input <= v;
      #1 chk(sector_detected_set, e);
   endtask
   initial begin
      {psel, penable, pwrite, byte_carry, sector_count_zero, start_load, branch_cond} = 0;
      {branch_is_edge, dual_source, dual_pick_data, inh_set_cmd, inh_clr_cmd} = 0;
      {sector_mark_edge_input, paddr, pwdata, start_addr, next_field, data_field} = 0;
      {err_total, comparisons, presetn} = 0;
      void'($urandom(32'h7375d1d4));
      repeat (16) @(posedge pclk);
      presetn <= 1;
      rd(12'h078, 8'h00);
      rd(12'h100, 8'h00);
      // random control bytes, reserved bits drop out
      for (i = 0; i < 4; i++) begin
         r = $urandom;
         r[3] = i[0];
         bus(1, 12'h077, {24'h0, r});
         rd(12'h077, r & 8'h3A);
         chk(buffer_to_formatter, r[3]);
      end
      // control writes only while the sequencer is quiet
      bus(1, 12'h077, 32'h10);
      carry(0, 0);
      carry(1, 0);
      rd(12'h077, 8'h00);
      carry(0, 1);
      rd(12'h080, 8'h02);
      bus(1, 12'h084, 32'h02);
      chk(irq, 1);
      bus(1, 12'h084, 32'h05);
      chk(irq, 0);
      bus(1, 12'h084, 32'h07);
      bus(1, 12'h080, 32'h02);
      chk(irq, 0);
      inh_set_cmd <= 1;
      rd(12'h077, 8'h10);
      inh_set_cmd <= 0;
      inh_clr_cmd <= 1;
      rd(12'h077, 8'h00);
      inh_clr_cmd <= 0;
      // start, plain step, then each branch source
      b = $urandom;
      start_addr <= $urandom;
      next_field <= $urandom;
      data_field <= ~b;
      start_load <= 1;
      bus(1, 12'h078, {24'h0, 3'b111, b});
      start_load <= 0;
      rd(12'h078, {3'b0, start_addr});
      carry(0, 1);
      rd(12'h078, {3'b0, next_field});
      branch_cond <= 1;
      carry(0, 1);
      rd(12'h078, {3'b0, b});
      bus(1, 12'h077, 32'h02);
      carry(0, 1);
      rd(12'h078, {3'b0, data_field});
      dual_source <= 1;
      carry(0, 1);
      rd(12'h078, {3'b0, b});
      {branch_cond, dual_source} <= 0;
      // rising only, then falling only steering a branch
      bus(1, 12'h077, 32'h00);
      mk(1, 1);
      mk(0, 0);
      bus(1, 12'h077, 32'h28);
      mk(1, 0);
      branch_is_edge <= 1;
      byte_carry <= 1;
      mk(0, 1);
      @(posedge pclk);
      {byte_carry, branch_is_edge} <= 0;
      rd(12'h078, {3'b0, b});
      bus(1, 12'h04F, 32'h01);
      rd(12'h078, 8'h00);
      chk(buffer_to_formatter, 0);
      chk(pslverr, 0);
      repeat (2) @(posedge pclk);
      conclude();
   end
   // hang guard, far beyond the expected run
   initial begin
      #200000;
      err_total++;
      conclude();
   end
endmodule // test_format_sequencer_branch_control
bind fsbc_top fsbc_monitor mon (.*);
